/* File: common/adcsc_pkg.sv */
// Purpose: Shared constants and carrier types for the converter sequence status and compare block.
// Assumes: AHB-Lite slave with 32-bit data; each register takes one aligned word.
// Notes:   Printed offsets are word indices; the byte address is four times the index.
`default_nettype none
package adcsc_pkg;

  // Register word indices (byte address = index * 4)
  localparam logic [7:0]  SEQ_STATUS_IDX   = 8'h06;
  localparam logic [7:0]  CMP_ENABLE_IDX   = 8'h08;
  localparam logic [7:0]  CTRL_IDX         = 8'h10;
  localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h11;
  localparam logic [7:0]  IRQ_MASK_IDX     = 8'h12;

  // sequence_status fields
  localparam int          SCF_BIT          = 7;
  localparam int          TORF_BIT         = 5;
  localparam int          RORF_BIT         = 4;
  localparam int          CNT_LSB          = 0;

  // Control register fields
  localparam int          CTRL_FIFO_BIT    = 0;
  localparam int          CTRL_FFC_BIT     = 1;
  localparam int          CTRL_LVL_BIT     = 2;

  // Interrupt status / mask fields
  localparam int          IRQ_SEQ_BIT      = 0;
  localparam int          IRQ_TORF_BIT     = 1;
  localparam int          IRQ_RORF_BIT     = 2;

  // Reset values
  localparam logic [15:0] CMPE_RST         = 16'h0000;
  localparam logic [3:0]  CNT_RST          = 4'h0;
  localparam logic [2:0]  CTRL_RST         = 3'h0;
  localparam logic [2:0]  IRQ_MASK_RST     = 3'h0;

  // AHB-Lite
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic        HRESP_OKAY       = 1'b0;

  // Converter-side event bundle
  typedef struct packed {
    logic        done;        // One-cycle pulse at end of a conversion
    logic        last;        // The finishing conversion closes the sequence
    logic [15:0] result;      // Fresh conversion result
    logic [15:0] slot_value;  // Current content of the slot's result register
    logic        slot_ccf;    // Slot's conversion done flag still set
  } adcsc_conv_t;

  // Slot-side action bundle
  typedef struct packed {
    logic        store;       // Write result into the slot's result register
    logic        flag_set;    // Set the slot's conversion done flag
    logic        abort;       // Abort the running sequence
  } adcsc_slot_t;

  // Captured AHB address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  idx;
  } adcsc_dph_t;

  // Complete module state
  typedef struct packed {
    adcsc_dph_t  dph;
    logic        busy;
    logic        seq_flag;
    logic        trig_ovr;
    logic        res_ovr;
    logic [3:0]  cnt;
    logic [15:0] cmpe;
    logic [2:0]  ctrl;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
  } adcsc_state_t;

endpackage
`default_nettype wire

/* File: rtl/adcsc_top.sv */
// Purpose: Sequence status flags, conversion counter and automatic compare control for an ADC sequencer.
// Assumes: Converter, result registers and control registers live outside and connect by pulses.
// Notes:   Zero-wait AHB-Lite slave; only whole-word accesses are meaningful.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: Set sequence complete flag at each finished sequence, again each sequence in scan mode.
// R2: Clear it by writing one, by start-conversion write, or result read with fast clear.
// R3: In edge trigger mode, a trigger edge during a running sequence sets trigger overrun.
// R4: Clear trigger overrun by writing one, by any aborting write, or start write.
// R5: Set result overrun when a result register is written while its done flag is set.
// R6: Clear result overrun by writing one, by any aborting write, or start write.
// R7: Keep a read-only 4-bit conversion counter indexing the current result slot.
// R8: Without FIFO mode reset counter at sequence start and end; FIFO mode keeps counting up at sequence end.
// R9: The conversion counter wraps from fifteen back to zero and keeps counting.
// R10: Aborting or starting a conversion clears the counter, also in FIFO mode.
// R11: Status writes are accepted anytime but never change the conversion counter.
// R12: Any write to the compare enable register aborts the running sequence.
// R13: Sixteen compare enable bits, one per position, sense taken from operator bit.
// R14: Software loads the compare value first, then programs the operator bit.
// R15: A successful compare is reported through that position's done flag.
// R16: With compare enabled, set done flag only on a true compare and discard result.
// R17: Operator zero: true when result is lower or equal; operator one: when higher.
// R18: Unused status bits read as zero and ignore writes.
module adcsc_top
  import adcsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Events from surrounding sequencer logic
  input  wire logic        start_wr,
  input  wire logic        ctl_wr,
  input  wire logic        scan_mode,
  input  wire logic        trig_edge,
  input  wire logic        result_read,
  input  wire logic [15:0] compare_operator_bits,
  input  wire adcsc_conv_t conv,
  // Slot actions and status
  output adcsc_slot_t      slot,
  output logic [3:0]       conversion_counter,
  output logic             seq_busy,
  output logic             irq
);

  adcsc_state_t s_r;
  adcsc_state_t s_nxt;

  logic        wr_stat;
  logic        wr_cmpe;
  logic        wr_ctrl;
  logic        wr_irqs;
  logic        wr_irqm;
  logic        abort_any;
  logic        conv_ev;
  logic        cmp_on;
  logic        cmp_true;
  logic        seq_set;
  logic        torf_set;
  logic        rorf_set;
  logic        fifo_mode;
  logic        fast_flag_clear;
  logic        trigger_level_select;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and converter events

  assign fifo_mode            = s_r.ctrl[CTRL_FIFO_BIT];
  assign fast_flag_clear      = s_r.ctrl[CTRL_FFC_BIT];
  assign trigger_level_select = s_r.ctrl[CTRL_LVL_BIT];

  assign wr_stat   = s_r.dph.valid && s_r.dph.write && (s_r.dph.idx == SEQ_STATUS_IDX); // R11
  assign wr_cmpe   = s_r.dph.valid && s_r.dph.write && (s_r.dph.idx == CMP_ENABLE_IDX);
  assign wr_ctrl   = s_r.dph.valid && s_r.dph.write && (s_r.dph.idx == CTRL_IDX);
  assign wr_irqs   = s_r.dph.valid && s_r.dph.write && (s_r.dph.idx == IRQ_STATUS_IDX);
  assign wr_irqm   = s_r.dph.valid && s_r.dph.write && (s_r.dph.idx == IRQ_MASK_IDX);

  // Aborting writes: outside control and operator registers, or compare enable
  assign abort_any = ctl_wr || wr_cmpe; // R12

  // Conversions outside a running sequence are ignored
  assign conv_ev   = conv.done && s_r.busy;

  // Compare: enable bit and operator picked by the counter position
  assign cmp_on    = s_r.cmpe[s_r.cnt]; // R13
  assign cmp_true  = compare_operator_bits[s_r.cnt] ? (conv.result > conv.slot_value)
                                                    : (conv.result <= conv.slot_value); // R17

  assign slot = '{store:    conv_ev && !cmp_on,                      // R16
                  flag_set: conv_ev && (cmp_on ? cmp_true : 1'b1),  // R15 R16
                  abort:    abort_any};                             // R12

  assign seq_set  = conv_ev && conv.last; // R1
  assign torf_set = trig_edge && s_r.busy && !trigger_level_select; // R3
  assign rorf_set = slot.store && conv.slot_ccf; // R5

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_nxt = s_r;

    s_nxt.dph.valid = hsel && hready && (htrans == HTRANS_NONSEQ);
    s_nxt.dph.write = hwrite;
    s_nxt.dph.idx   = haddr[9:2];

    // Sets win over software clears; start and abort clears win over sets
    s_nxt.seq_flag = (s_r.seq_flag && !(wr_stat && hwdata[SCF_BIT])
                     && !(fast_flag_clear && result_read)) || seq_set; // R1 R2
    s_nxt.trig_ovr = (s_r.trig_ovr && !(wr_stat && hwdata[TORF_BIT])) || torf_set; // R3 R4
    s_nxt.res_ovr  = (s_r.res_ovr && !(wr_stat && hwdata[RORF_BIT])) || rorf_set; // R5 R6

    // Counter advances per conversion, resets after the last one outside FIFO mode; status writes leave it alone
    if (conv_ev)
    begin
      if (conv.last && !fifo_mode)
        s_nxt.cnt = CNT_RST; // R8
      else
        s_nxt.cnt = s_r.cnt + 4'h1; // R7 R9
      if (conv.last && !scan_mode)
        s_nxt.busy = 1'b0;
    end

    if (abort_any)
    begin
      s_nxt.busy     = 1'b0; // R12
      s_nxt.cnt      = CNT_RST; // R10
      s_nxt.trig_ovr = 1'b0; // R4
      s_nxt.res_ovr  = 1'b0; // R6
    end

    // A start write aborts and restarts, so it takes precedence
    if (start_wr)
    begin
      s_nxt.busy     = 1'b1;
      s_nxt.cnt      = CNT_RST; // R8 R10
      s_nxt.seq_flag = 1'b0; // R2
      s_nxt.trig_ovr = 1'b0; // R4
      s_nxt.res_ovr  = 1'b0; // R6
    end

    if (wr_cmpe)
      s_nxt.cmpe = hwdata[15:0]; // R13
    if (wr_ctrl)
      s_nxt.ctrl = hwdata[2:0];
    if (wr_irqm)
      s_nxt.irq_mask = hwdata[2:0];

    s_nxt.irq_stat = (s_r.irq_stat & ~(wr_irqs ? hwdata[2:0] : 3'h0))
                     | {rorf_set, torf_set, seq_set};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r          <= '0;
      s_r.cnt      <= CNT_RST;
      s_r.cmpe     <= CMPE_RST;
      s_r.ctrl     <= CTRL_RST;
      s_r.irq_mask <= IRQ_MASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers and outputs

  // Read mux works on the data phase so a read just after a write sees fresh data
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (s_r.dph.valid && !s_r.dph.write)
    begin
      unique case (s_r.dph.idx)
        SEQ_STATUS_IDX:
        begin
          hrdata[SCF_BIT]          = s_r.seq_flag;
          hrdata[TORF_BIT]         = s_r.trig_ovr;
          hrdata[RORF_BIT]         = s_r.res_ovr;
          hrdata[CNT_LSB+3:CNT_LSB] = s_r.cnt; // R7 R18
        end
        CMP_ENABLE_IDX: hrdata[15:0] = s_r.cmpe;
        CTRL_IDX:       hrdata[2:0]  = s_r.ctrl;
        IRQ_STATUS_IDX: hrdata[2:0]  = s_r.irq_stat;
        IRQ_MASK_IDX:   hrdata[2:0]  = s_r.irq_mask;
        default:        hrdata       = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout          = 1'b1;
  assign hresp              = HRESP_OKAY;
  assign conversion_counter = s_r.cnt;
  assign seq_busy           = s_r.busy;
  assign irq                = |(s_r.irq_stat & s_r.irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic quiet;
  assign quiet = !start_wr && !abort_any;

  sequence s_abort_then_idle;
    slot.abort ##1 (!seq_busy && conversion_counter == 4'h0);
  endsequence

  property p_seq_set;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && conv.last && !start_wr) |=> s_r.seq_flag;
  endproperty
  a_seq_set: assert property (p_seq_set) else $error("sequence flag not set"); // R1

  property p_seq_clr_start;
    @(posedge clk) disable iff (!nrst)
    start_wr |=> !s_r.seq_flag && seq_busy && conversion_counter == 4'h0;
  endproperty
  a_seq_clr_start: assert property (p_seq_clr_start) else $error("start did not clear"); // R2

  property p_torf_set;
    @(posedge clk) disable iff (!nrst)
    (trig_edge && seq_busy && !trigger_level_select && quiet) |=> s_r.trig_ovr;
  endproperty
  a_torf_set: assert property (p_torf_set) else $error("trigger overrun missed"); // R3

  property p_torf_clr;
    @(posedge clk) disable iff (!nrst)
    abort_any |=> !s_r.trig_ovr;
  endproperty
  a_torf_clr: assert property (p_torf_clr) else $error("trigger overrun kept"); // R4

  property p_rorf_set;
    @(posedge clk) disable iff (!nrst)
    (slot.store && conv.slot_ccf && quiet) |=> s_r.res_ovr;
  endproperty
  a_rorf_set: assert property (p_rorf_set) else $error("result overrun missed"); // R5

  property p_rorf_clr;
    @(posedge clk) disable iff (!nrst)
    (abort_any || start_wr) |=> !s_r.res_ovr;
  endproperty
  a_rorf_clr: assert property (p_rorf_clr) else $error("result overrun kept"); // R6

  property p_cnt_end;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && conv.last && !fifo_mode) |=> conversion_counter == 4'h0;
  endproperty
  a_cnt_end: assert property (p_cnt_end) else $error("counter not reset at end"); // R8

  property p_cnt_step;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && !conv.last && quiet)
      |=> conversion_counter == ($past(conversion_counter) + 4'h1);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter step or wrap wrong"); // R9

  property p_cnt_abort;
    @(posedge clk) disable iff (!nrst)
    abort_any && !start_wr |-> s_abort_then_idle;
  endproperty
  a_cnt_abort: assert property (p_cnt_abort) else $error("abort did not stop"); // R10

  property p_stat_wr;
    @(posedge clk) disable iff (!nrst)
    (wr_stat && !conv.done && quiet) |=> $stable(conversion_counter);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write moved counter"); // R11

  property p_cmpe_abort;
    @(posedge clk) disable iff (!nrst)
    (wr_cmpe && !start_wr) |-> s_abort_then_idle;
  endproperty
  a_cmpe_abort: assert property (p_cmpe_abort) else $error("compare write no abort"); // R12

  property p_cmp_discard;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && s_r.cmpe[conversion_counter])
      |-> !slot.store && (slot.flag_set == (compare_operator_bits[conversion_counter]
                                            ? (conv.result > conv.slot_value)
                                            : (conv.result <= conv.slot_value)));
  endproperty
  a_cmp_discard: assert property (p_cmp_discard) else $error("compare slot mishandled"); // R16

  // Software clears lose against a set in the same cycle, so those cycles are left out
  property p_seq_w1c;
    @(posedge clk) disable iff (!nrst)
    (wr_stat && hwdata[SCF_BIT] && !(conv.done && seq_busy && conv.last)) |=> !s_r.seq_flag;
  endproperty
  a_seq_w1c: assert property (p_seq_w1c) else $error("sequence flag not cleared by write"); // R2

  property p_fast_clr;
    @(posedge clk) disable iff (!nrst)
    (fast_flag_clear && result_read && !(conv.done && seq_busy && conv.last)) |=> !s_r.seq_flag;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("fast clear missed"); // R2

  property p_busy_end;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && conv.last && quiet) |=> seq_busy == $past(scan_mode);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy wrong after last conversion"); // R1

  property p_torf_level;
    @(posedge clk) disable iff (!nrst)
    (trig_edge && seq_busy && trigger_level_select && !s_r.trig_ovr) |=> !s_r.trig_ovr;
  endproperty
  a_torf_level: assert property (p_torf_level) else $error("trigger overrun in level mode"); // R3

  property p_torf_w1c;
    @(posedge clk) disable iff (!nrst)
    (wr_stat && hwdata[TORF_BIT] && !(trig_edge && seq_busy && !trigger_level_select)) |=> !s_r.trig_ovr;
  endproperty
  a_torf_w1c: assert property (p_torf_w1c) else $error("trigger overrun not cleared by write"); // R4

  property p_rorf_w1c;
    @(posedge clk) disable iff (!nrst)
    (wr_stat && hwdata[RORF_BIT] && !(slot.store && conv.slot_ccf)) |=> !s_r.res_ovr;
  endproperty
  a_rorf_w1c: assert property (p_rorf_w1c) else $error("result overrun not cleared by write"); // R6

  property p_cnt_fifo;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && conv.last && fifo_mode && quiet)
      |=> conversion_counter == ($past(conversion_counter) + 4'h1);
  endproperty
  a_cnt_fifo: assert property (p_cnt_fifo) else $error("counter reset in fifo mode"); // R8

  property p_stat_read;
    @(posedge clk) disable iff (!nrst)
    (s_r.dph.valid && !s_r.dph.write && s_r.dph.idx == SEQ_STATUS_IDX)
      |-> (hrdata[31:8] == 24'h0 && !hrdata[6] && hrdata[3:0] == conversion_counter);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read layout wrong"); // R18

  property p_cmpe_load;
    @(posedge clk) disable iff (!nrst)
    wr_cmpe |=> s_r.cmpe == $past(hwdata[15:0]);
  endproperty
  a_cmpe_load: assert property (p_cmpe_load) else $error("compare enable not loaded"); // R13

  property p_plain_store;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && !s_r.cmpe[conversion_counter]) |-> slot.store && slot.flag_set;
  endproperty
  a_plain_store: assert property (p_plain_store) else $error("plain slot not stored"); // R16

  // Compare positions never store, so they can never lose unread data
  property p_rorf_cmp;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && s_r.cmpe[conversion_counter] && !s_r.res_ovr) |=> !s_r.res_ovr;
  endproperty
  a_rorf_cmp: assert property (p_rorf_cmp) else $error("overrun from compare slot"); // R16

  property p_irq_seq;
    @(posedge clk) disable iff (!nrst)
    (conv.done && seq_busy && conv.last && s_r.irq_mask[IRQ_SEQ_BIT] && !wr_irqm) |=> irq;
  endproperty
  a_irq_seq: assert property (p_irq_seq) else $error("interrupt not raised");

  property p_irq_clr;
    @(posedge clk) disable iff (!nrst)
    (wr_irqs && hwdata[IRQ_SEQ_BIT] && !(conv.done && seq_busy && conv.last))
      |=> !s_r.irq_stat[IRQ_SEQ_BIT];
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt status not cleared");

endmodule // adcsc_top
`default_nettype wire

/* File: verification/test_adc_sequence_status_compare.sv */
// Purpose: Self-checking bench for the sequence status and compare block.
// Assumes: Zero-wait AHB-Lite slave; the bench plays the sequencer around it.
// Notes:   Event pulses last one cycle; slot actions are sampled inside that cycle.
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequence_status_compare
  import adcsc_pkg::*;
;
  localparam logic [31:0] A_ST  = {22'h0, SEQ_STATUS_IDX, 2'h0};
  localparam logic [31:0] A_CE  = {22'h0, CMP_ENABLE_IDX, 2'h0};
  localparam logic [31:0] A_CTL = {22'h0, CTRL_IDX, 2'h0};
  localparam logic [31:0] A_IS  = {22'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [31:0] A_IM  = {22'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [3:0]  S = 4'h1, A = 4'h2, T = 4'h4, R = 4'h8;

  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        start_wr = 1'b0, ctl_wr = 1'b0, trig_edge = 1'b0, result_read = 1'b0, scan_mode = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] cmp_op = 16'h0;
  adcsc_conv_t conv = '0;
  adcsc_slot_t slot;
  logic        hreadyout, hresp, seq_busy, irq;
  logic [31:0] hrdata;
  logic [3:0]  cnt;
  int          mismatches = 0, checks_done = 0, cycles = 0;

  always #2 clk = ~clk;

  adcsc_top u_adcsc_top (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .start_wr(start_wr), .ctl_wr(ctl_wr), .scan_mode(scan_mode),
    .trig_edge(trig_edge), .result_read(result_read), .compare_operator_bits(cmp_op),
    .conv(conv), .slot(slot), .conversion_counter(cnt), .seq_busy(seq_busy), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Drives by NBA just after a rising edge; hready and read data are taken at rising edges
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    chk("hready", 32'h1, {31'h0, hreadyout});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(what, e, rd);
  endtask

  task automatic st(input logic [7:0] e);
    rdc("status", A_ST, {24'h0, e});
  endtask

  task automatic ev(input logic [3:0] k);
    @(posedge clk);
    {result_read, trig_edge, ctl_wr, start_wr} <= k;
    @(posedge clk);
    {result_read, trig_edge, ctl_wr, start_wr} <= 4'h0;
    #1;
  endtask

  // Expected slot actions as {store, flag_set, abort}
  task automatic cv(input logic last, input logic ccf, input logic [15:0] r, input logic [15:0] v,
                    input logic [2:0] e);
    @(posedge clk);
    conv <= {1'b1, last, r, v, ccf};
    #1 chk("slot", {29'h0, e}, {29'h0, slot});
    @(posedge clk);
    conv <= '0;
    #1;
  endtask

  task automatic cmp1(input logic op, input logic [15:0] r, input logic [2:0] e);
    cmp_op <= {15'h0, op};
    ev(S);
    cv(1'b0, 1'b1, r, 16'h0100, e);
    st(8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      wrap_up;
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    st(8'h00);
    rdc("cmpe", A_CE, 32'h0);
    rdc("ctrl", A_CTL, 32'h0);
    rdc("unmapped", 32'h1C, 32'h0);
    wr(32'h1C, 32'hFFFF_FFFF);
    rdc("unmapped", 32'h1C, 32'h0);
    ev(S);
    chk("busy", 32'h1, {31'h0, seq_busy});
    chk("counter", 32'h0, {28'h0, cnt});
    cv(1'b0, 1'b0, 16'h0011, 16'h0, 3'h6);
    cv(1'b0, 1'b0, 16'h0022, 16'h0, 3'h6);
    wr(A_ST, 32'hFF);
    st(8'h02);
    ev(T);
    st(8'h22);
    cv(1'b0, 1'b1, 16'h0033, 16'h0, 3'h6);
    st(8'h33);
    cv(1'b1, 1'b0, 16'h0044, 16'h0, 3'h6);
    st(8'hB0);
    #1 chk("busy", 32'h0, {31'h0, seq_busy});
    chk("irq", 32'h0, {31'h0, irq});
    wr(A_IM, 32'h1);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(A_IS, 32'h7);
    #1 chk("irq", 32'h0, {31'h0, irq});
    wr(A_ST, 32'h30);
    st(8'h80);
    wr(A_ST, 32'h80);
    st(8'h00);
    ev(S);
    ev(T);
    cv(1'b1, 1'b1, 16'h0, 16'h0, 3'h6);
    st(8'hB0);
    ev(S);
    st(8'h00);
    ev(T);
    cv(1'b0, 1'b1, 16'h0, 16'h0, 3'h6);
    st(8'h31);
    ev(A);
    st(8'h00);
    ev(S);
    cv(1'b0, 1'b0, 16'h0, 16'h0, 3'h6);
    ev(T);
    st(8'h21);
    wr(A_CE, 32'hFFFF_0001);
    st(8'h00);
    #1 chk("busy", 32'h0, {31'h0, seq_busy});
    rdc("cmpe", A_CE, 32'h0001);
    cmp1(1'b0, 16'h0100, 3'h2);
    cmp1(1'b0, 16'h0101, 3'h0);
    cmp1(1'b1, 16'h0101, 3'h2);
    cmp1(1'b1, 16'h0100, 3'h0);
    wr(A_CE, 32'h0);
    wr(A_CTL, 32'h1);
    ev(S);
    cv(1'b1, 1'b0, 16'h0, 16'h0, 3'h6);
    st(8'h81);
    ev(S);
    st(8'h00);
    for (int i = 0; i < 17; i++)
      cv(1'b0, 1'b0, 16'h0, 16'h0, 3'h6);
    st(8'h01);
    #1 chk("counter", 32'h1, {28'h0, cnt});
    wr(A_CTL, 32'h2);
    cv(1'b1, 1'b0, 16'h0, 16'h0, 3'h6);
    st(8'h80);
    ev(R);
    st(8'h00);
    wr(A_CTL, 32'h4);
    ev(S);
    ev(T);
    st(8'h00);
    scan_mode <= 1'b1;
    cv(1'b1, 1'b0, 16'h0, 16'h0, 3'h6);
    chk("busy", 32'h1, {31'h0, seq_busy});
    wr(A_ST, 32'h80);
    cv(1'b1, 1'b0, 16'h0, 16'h0, 3'h6);
    st(8'h80);
    wrap_up;
  end
endmodule // test_adc_sequence_status_compare
`default_nettype wire
